// >>> core/iptm_pkg.sv
package iptm_pkg;

    // ****************************************************************
    // phase lengths, in pci clocks
    // ****************************************************************
    localparam logic [4:0] NDATA_STARTUP   = 5'h04;
    localparam logic [4:0] NDATA_ISP       = 5'h0b;
    localparam logic [4:0] NDATA_RCT       = 5'h16;
    localparam logic [4:0] CDATA_STARTUP   = 5'h03;
    localparam logic [4:0] CDATA_ISP       = 5'h06;
    localparam logic [4:0] CDATA_RCT       = 5'h0e;
    localparam logic [4:0] ENH_STARTUP     = 5'h02;
    localparam logic [4:0] ENH_ISP_BASE    = 5'h02;
    localparam logic [4:0] ENH_RCT_BASE    = 5'h01;
    localparam logic [4:0] SHUTDOWN_CLKS   = 5'h02;
    localparam logic [4:0] CS_GAP_CLKS     = 5'h02;
    localparam logic [4:0] READY_WAIT_MIN  = 5'h02;
    // extra compatible recovery for 16-bit isa recovery (arbitrary)
    localparam logic [4:0] ISA_EXTRA_RCT   = 5'h04;

    // ****************************************************************
    // pin encodings
    // ****************************************************************
    localparam logic [1:0] CS_NONE = 2'h3;

    // ****************************************************************
    // carriers
    // ****************************************************************
    typedef struct packed {
        logic        is_data;
        logic        write;
        logic        is32;
        logic [1:0]  cs_sel;
        logic [2:0]  addr;
        logic [31:0] wdata;
    } iptm_req_s;

    typedef struct packed {
        logic [1:0] ready_sample_point;
        logic [1:0] recovery_clocks;
    } iptm_tim_s;

    typedef struct packed {
        logic      drive0_fast_en;
        logic      drive1_fast_en;
        logic      drive0_ready_sample_en;
        logic      drive1_ready_sample_en;
        logic      separate_drive1_timing_en;
        logic      prefetch_en;
        logic      post_en;
        logic      isa_recovery_timer_16b_en;
        iptm_tim_s primary_drive_timing_reg;
        iptm_tim_s drive1_alt_timing_reg;
    } iptm_cfg_s;

    typedef enum logic [6:0] {
        ST_IDLE     = 7'h01,
        ST_STARTUP  = 7'h02,
        ST_STROBE   = 7'h04,
        ST_WAIT     = 7'h08,
        ST_RECOVER  = 7'h10,
        ST_SHUTDOWN = 7'h20,
        ST_GAP      = 7'h40
    } iptm_state_e;

endpackage

// >>> core/iptm_sync.sv
`timescale 1ns/1ps
`default_nettype none

// two-flop synchroniser; first stage feeds only the second
module iptm_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         resetn,
    input  wire logic         clk_en,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] q_nxt;

    // hold both stages while frozen
    always_comb begin
        meta_nxt = clk_en ? d : meta_r;
        q_nxt    = clk_en ? meta_r : q;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= meta_nxt;
            q      <= q_nxt;
        end
    end
endmodule

`default_nettype wire

// >>> core/iptm_phase_cnt.sv
`timescale 1ns/1ps
`default_nettype none

// phase counter: a load of n makes done rise on the n-th cycle
module iptm_phase_cnt (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       clk_en,
    input  wire logic       load,
    input  wire logic [4:0] load_val,
    output logic            done
);
    logic [4:0] cnt_r;
    logic [4:0] cnt_nxt;

    // saturates at one so done holds while a wait lingers
    always_comb begin
        cnt_nxt = cnt_r;
        if (clk_en) begin
            if (load)
                cnt_nxt = load_val;
            else if (cnt_r > 5'h01)
                cnt_nxt = cnt_r - 5'h01;
        end
        done = (cnt_r == 5'h01);
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn)
            cnt_r <= 5'h01;
        else
            cnt_r <= cnt_nxt;
    end
endmodule

`default_nettype wire

// >>> core/iptm_engine.sv
`timescale 1ns/1ps
`default_nettype none

module iptm_engine (
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire logic              clk_en,
    input  wire logic              req_valid,
    input  wire iptm_pkg::iptm_req_s req,
    output logic                   req_ready,
    output logic                   rsp_valid,
    output logic            [31:0] rsp_rdata,
    input  wire iptm_pkg::iptm_cfg_s cfg,
    input  wire logic              target_drive,
    output logic             [2:0] ide_addr_lines,
    output logic             [1:0] ide_chip_selects_n,
    output logic                   ide_read_strobe_n,
    output logic                   ide_write_strobe_n,
    input  wire logic       [15:0] ide_data_in,
    output logic            [15:0] ide_data_out,
    output logic                   ide_data_oe,
    input  wire logic              drive_io_ready
);
    // ****************************************************************
    // state
    // ****************************************************************
    iptm_pkg::iptm_state_e st_r,   st_nxt;
    iptm_pkg::iptm_req_s   cur_r,  cur_nxt;
    logic                  drive_r,     drive_nxt;
    logic                  half_r,      half_nxt;
    logic                  more_r,      more_nxt;
    logic                  pf_cyc_r,    pf_cyc_nxt;
    logic                  pf_val_r,    pf_val_nxt;
    logic                  posted_r,    posted_nxt;
    logic           [31:0] pf_data_r,   pf_data_nxt;
    logic           [31:0] acc_r,       acc_nxt;
    logic                  ready_nxt;
    logic                  rsp_valid_nxt;
    logic           [31:0] rsp_rdata_nxt;
    logic            [2:0] addr_nxt;
    logic            [1:0] cs_n_nxt;
    logic                  rd_n_nxt;
    logic                  wr_n_nxt;
    logic           [15:0] dout_nxt;
    logic                  doe_nxt;

    logic                  take;
    logic                  cnt_load;
    logic            [4:0] cnt_val;
    logic                  cnt_done;
    logic                  ready_s;
    logic           [15:0] data_s;
    iptm_pkg::iptm_req_s   sel;
    logic                  sel_drv;
    logic                  fast;
    logic                  sample_en;
    iptm_pkg::iptm_tim_s   tim;
    logic            [4:0] startup_len;
    logic            [4:0] isp_len;
    logic            [4:0] rct_len;
    logic                  strobe_end;
    logic                  unit_last;
    logic                  cs_act;
    logic                  stb_act;

    // ****************************************************************
    // pin synchronisers and phase counter
    // ****************************************************************
    iptm_sync #(.W(1)) u_ready_sync (
        .clk    (clk),
        .resetn (resetn),
        .clk_en (clk_en),
        .d      (drive_io_ready),
        .q      (ready_s)
    );

    iptm_sync #(.W(16)) u_data_sync (
        .clk    (clk),
        .resetn (resetn),
        .clk_en (clk_en),
        .d      (ide_data_in),
        .q      (data_s)
    );

    iptm_phase_cnt u_cnt (
        .clk      (clk),
        .resetn   (resetn),
        .clk_en   (clk_en),
        .load     (cnt_load),
        .load_val (cnt_val),
        .done     (cnt_done)
    );

    // ****************************************************************
    // timing selection
    // ****************************************************************
    // idle looks at the incoming request, otherwise the running one
    always_comb begin
        take    = req_valid && req_ready && (st_r == iptm_pkg::ST_IDLE);
        sel     = take ? req : cur_r;
        sel_drv = take ? target_drive : drive_r;
        // dma mode is not an input: pio timing never depends on it
        fast = sel.is_data && (sel_drv ? cfg.drive1_fast_en
                                       : cfg.drive0_fast_en);
        sample_en = sel_drv ? cfg.drive1_ready_sample_en
                            : cfg.drive0_ready_sample_en;
        if (sel_drv && cfg.separate_drive1_timing_en)
            tim = cfg.drive1_alt_timing_reg;
        else
            tim = cfg.primary_drive_timing_reg;
        if (fast) begin
            startup_len = iptm_pkg::ENH_STARTUP;
            isp_len = iptm_pkg::ENH_ISP_BASE
                      + {3'h0, tim.ready_sample_point};
            rct_len = iptm_pkg::ENH_RCT_BASE
                      + {3'h0, tim.recovery_clocks};
        end else if (sel.is_data) begin
            startup_len = iptm_pkg::CDATA_STARTUP;
            isp_len     = iptm_pkg::CDATA_ISP;
            rct_len     = iptm_pkg::CDATA_RCT;
            // isa recovery only stretches compatible data reads
            if (cfg.isa_recovery_timer_16b_en && !sel.write)
                rct_len = iptm_pkg::CDATA_RCT
                          + iptm_pkg::ISA_EXTRA_RCT;
        end else begin
            startup_len = iptm_pkg::NDATA_STARTUP;
            isp_len     = iptm_pkg::NDATA_ISP;
            rct_len     = iptm_pkg::NDATA_RCT;
        end
    end

    // ****************************************************************
    // sequencer
    // ****************************************************************
    // one request in flight; a busy engine refuses new ones
    always_comb begin
        st_nxt        = st_r;
        cur_nxt       = cur_r;
        drive_nxt     = drive_r;
        half_nxt      = half_r;
        more_nxt      = more_r;
        pf_cyc_nxt    = pf_cyc_r;
        pf_val_nxt    = pf_val_r;
        pf_data_nxt   = pf_data_r;
        posted_nxt    = posted_r;
        acc_nxt       = acc_r;
        rsp_valid_nxt = 1'b0;
        rsp_rdata_nxt = rsp_rdata;
        cnt_load      = 1'b0;
        cnt_val       = startup_len;
        strobe_end    = 1'b0;
        unit_last     = !cur_r.is32 || half_r;
        unique case (st_r)
            iptm_pkg::ST_IDLE: begin
                if (take) begin
                    cur_nxt    = req;
                    drive_nxt  = target_drive;
                    half_nxt   = 1'b0;
                    more_nxt   = 1'b0;
                    pf_cyc_nxt = 1'b0;
                    posted_nxt = 1'b0;
                    pf_val_nxt = 1'b0;
                    st_nxt     = iptm_pkg::ST_STARTUP;
                    cnt_load   = 1'b1;
                    if (req.is_data && !req.write && pf_val_r
                        && cfg.prefetch_en) begin
                        // served at once, next word fetched behind it
                        rsp_valid_nxt = 1'b1;
                        rsp_rdata_nxt = pf_data_r;
                        pf_cyc_nxt    = 1'b1;
                    end else if (req.is_data && req.write
                                 && cfg.post_en) begin
                        rsp_valid_nxt = 1'b1;
                        rsp_rdata_nxt = 32'h0000_0000;
                        posted_nxt    = 1'b1;
                    end
                end
            end
            iptm_pkg::ST_STARTUP: begin
                if (cnt_done) begin
                    st_nxt   = iptm_pkg::ST_STROBE;
                    cnt_load = 1'b1;
                    cnt_val  = isp_len;
                end
            end
            iptm_pkg::ST_STROBE: begin
                if (cnt_done) begin
                    if (!sample_en || ready_s) begin
                        strobe_end = 1'b1;
                    end else begin
                        st_nxt   = iptm_pkg::ST_WAIT;
                        cnt_load = 1'b1;
                        cnt_val  = iptm_pkg::READY_WAIT_MIN;
                    end
                end
            end
            iptm_pkg::ST_WAIT: begin
                strobe_end = cnt_done && ready_s;
            end
            iptm_pkg::ST_RECOVER: begin
                if (cnt_done) begin
                    if (!unit_last) begin
                        half_nxt = 1'b1;
                        more_nxt = 1'b1;
                    end else begin
                        if (!cur_r.write && pf_cyc_r) begin
                            pf_data_nxt = acc_r;
                            pf_val_nxt  = 1'b1;
                        end else if (!posted_r) begin
                            rsp_valid_nxt = 1'b1;
                            rsp_rdata_nxt = cur_r.write ? 32'h0000_0000
                                                        : acc_r;
                        end
                        more_nxt = cur_r.is_data && !cur_r.write
                                   && cfg.prefetch_en && !pf_cyc_r;
                        if (more_nxt) begin
                            pf_cyc_nxt = 1'b1;
                            half_nxt   = 1'b0;
                        end
                    end
                    if (more_nxt && fast) begin
                        // selects stay set: no startup or shutdown
                        more_nxt = 1'b0;
                        st_nxt   = iptm_pkg::ST_STROBE;
                        cnt_load = 1'b1;
                        cnt_val  = isp_len;
                    end else begin
                        st_nxt   = iptm_pkg::ST_SHUTDOWN;
                        cnt_load = 1'b1;
                        cnt_val  = iptm_pkg::SHUTDOWN_CLKS;
                    end
                end
            end
            iptm_pkg::ST_SHUTDOWN: begin
                if (cnt_done) begin
                    st_nxt   = iptm_pkg::ST_GAP;
                    cnt_load = 1'b1;
                    cnt_val  = iptm_pkg::CS_GAP_CLKS;
                end
            end
            iptm_pkg::ST_GAP: begin
                if (cnt_done) begin
                    cnt_load = more_r;
                    more_nxt = 1'b0;
                    st_nxt   = more_r ? iptm_pkg::ST_STARTUP
                                      : iptm_pkg::ST_IDLE;
                end
            end
            default: begin
                st_nxt = iptm_pkg::ST_IDLE;
            end
        endcase
        // strobe over: take the read half, start recovery
        if (strobe_end) begin
            st_nxt   = iptm_pkg::ST_RECOVER;
            cnt_load = 1'b1;
            cnt_val  = rct_len;
            if (half_r)
                acc_nxt[31:16] = data_s;
            else
                acc_nxt[15:0] = data_s;
        end
        if (!clk_en) begin
            cnt_load = 1'b0;
        end
    end

    // ****************************************************************
    // pins follow the next state so they leave flip-flops
    // ****************************************************************
    always_comb begin
        cs_act   = (st_nxt != iptm_pkg::ST_IDLE)
                   && (st_nxt != iptm_pkg::ST_GAP);
        stb_act  = (st_nxt == iptm_pkg::ST_STROBE)
                   || (st_nxt == iptm_pkg::ST_WAIT);
        addr_nxt = cur_nxt.addr;
        cs_n_nxt = cs_act ? ~cur_nxt.cs_sel : iptm_pkg::CS_NONE;
        rd_n_nxt = !(stb_act && !cur_nxt.write);
        wr_n_nxt = !(stb_act && cur_nxt.write);
        dout_nxt = half_nxt ? cur_nxt.wdata[31:16]
                            : cur_nxt.wdata[15:0];
        doe_nxt  = cs_act && cur_nxt.write;
        // a posted write still drains before any new access
        ready_nxt = (st_nxt == iptm_pkg::ST_IDLE);
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_r               <= iptm_pkg::ST_IDLE;
            cur_r              <= '0;
            drive_r            <= 1'b0;
            half_r             <= 1'b0;
            more_r             <= 1'b0;
            pf_cyc_r           <= 1'b0;
            pf_val_r           <= 1'b0;
            pf_data_r          <= 32'h0000_0000;
            posted_r           <= 1'b0;
            acc_r              <= 32'h0000_0000;
            req_ready          <= 1'b0;
            rsp_valid          <= 1'b0;
            rsp_rdata          <= 32'h0000_0000;
            ide_addr_lines     <= 3'h0;
            ide_chip_selects_n <= iptm_pkg::CS_NONE;
            ide_read_strobe_n  <= 1'b1;
            ide_write_strobe_n <= 1'b1;
            ide_data_out       <= 16'h0000;
            ide_data_oe        <= 1'b0;
        end else if (clk_en) begin
            st_r               <= st_nxt;
            cur_r              <= cur_nxt;
            drive_r            <= drive_nxt;
            half_r             <= half_nxt;
            more_r             <= more_nxt;
            pf_cyc_r           <= pf_cyc_nxt;
            pf_val_r           <= pf_val_nxt;
            pf_data_r          <= pf_data_nxt;
            posted_r           <= posted_nxt;
            acc_r              <= acc_nxt;
            req_ready          <= ready_nxt;
            rsp_valid          <= rsp_valid_nxt;
            rsp_rdata          <= rsp_rdata_nxt;
            ide_addr_lines     <= addr_nxt;
            ide_chip_selects_n <= cs_n_nxt;
            ide_read_strobe_n  <= rd_n_nxt;
            ide_write_strobe_n <= wr_n_nxt;
            ide_data_out       <= dout_nxt;
            ide_data_oe        <= doe_nxt;
        end
    end

    // ****************************************************************
    // checks: cycles spent in the phase now ending
    // ****************************************************************
    logic [4:0] ph_len_r;
    logic       leave;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn)
            ph_len_r <= 5'h00;
        else if (clk_en)
            ph_len_r <= (st_nxt != st_r) ? 5'h00 : ph_len_r + 5'h01;
    end
    assign leave = clk_en && (st_nxt != st_r);

    AST_SETUP_FIRST: assert property (@(posedge clk) disable iff (!resetn)
        (!ide_read_strobe_n || !ide_write_strobe_n)
        |-> $past(ide_chip_selects_n) != iptm_pkg::CS_NONE)
        else $error("strobe without selects set up");
    AST_ENH_STROBE: assert property (@(posedge clk) disable iff (!resetn)
        leave && st_r == iptm_pkg::ST_STROBE && fast
        |-> ph_len_r + 5'h01 == isp_len)
        else $error("enhanced strobe width wrong");
    AST_ENH_RCT: assert property (@(posedge clk) disable iff (!resetn)
        leave && st_r == iptm_pkg::ST_RECOVER && fast
        |-> ph_len_r == {3'h0, tim.recovery_clocks})
        else $error("enhanced recovery wrong");
    AST_BACK2BACK: assert property (@(posedge clk) disable iff (!resetn)
        leave && st_r == iptm_pkg::ST_RECOVER && fast && !unit_last
        |=> st_r == iptm_pkg::ST_STROBE)
        else $error("fast cycle not back to back");
    AST_WAIT_MIN: assert property (@(posedge clk) disable iff (!resetn)
        leave && st_r == iptm_pkg::ST_WAIT |-> ph_len_r >= 5'h01)
        else $error("ready wait under two clocks");
    AST_SHUTDOWN: assert property (@(posedge clk) disable iff (!resetn)
        leave && st_r == iptm_pkg::ST_SHUTDOWN
        |-> ph_len_r == 5'h01 ##1 !ide_data_oe)
        else $error("shutdown not two clocks");
    AST_NDATA_RCT: assert property (@(posedge clk) disable iff (!resetn)
        leave && st_r == iptm_pkg::ST_RECOVER && !cur_r.is_data
        |-> ph_len_r == 5'h15)
        else $error("non-data recovery not 22");
    AST_CDATA_ISP: assert property (@(posedge clk) disable iff (!resetn)
        leave && st_r == iptm_pkg::ST_STROBE && cur_r.is_data && !fast
        |-> ph_len_r == 5'h05)
        else $error("compatible data strobe not 6");
    AST_CS_GAP: assert property (@(posedge clk) disable iff (!resetn)
        leave && st_r == iptm_pkg::ST_GAP
        |-> ph_len_r == 5'h01 && ide_chip_selects_n == iptm_pkg::CS_NONE)
        else $error("select gap under two clocks");
    AST_READY_MASK: assert property (@(posedge clk) disable iff (!resetn)
        clk_en && st_r == iptm_pkg::ST_STROBE && cnt_done && !sample_en
        |=> st_r == iptm_pkg::ST_RECOVER)
        else $error("masked ready still waited");
    AST_STALL: assert property (@(posedge clk) disable iff (!resetn)
        st_r != iptm_pkg::ST_IDLE |-> !req_ready)
        else $error("request accepted while busy");
endmodule

`default_nettype wire

// >>> tb/iptm_drive_model.sv
`timescale 1ns/1ps
`default_nettype none

// ********
// drive on the cable
// ********
module iptm_drive_model (
    input  wire logic        clk,
    input  wire logic [1:0]  cs_n,
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    input  wire logic        slow,
    output logic      [15:0] data,
    output logic             ready
);
    logic [3:0] lo_r;
    // strobe clock count; saturates so a stuck strobe cannot wrap
    always_ff @(posedge clk)
        lo_r <= (rd_n & wr_n) ? 4'h0 : lo_r + {3'h0, ~&lo_r};
    // a slow drive is not ready for its first four strobe clocks
    assign ready = !(slow && lo_r < 4'h4);
    // deselected bus shows the inverse, never a stale value
    assign data = (cs_n != 2'h3) ? 16'hc35a : 16'h3ca5;
endmodule
`default_nettype wire

// >>> tb/ide_pio_timing_engine_test.sv
`timescale 1ns/1ps
`default_nettype none

module ide_pio_timing_engine_test;
    logic                clk = 1'b0;
    logic                resetn = 1'b0;
    logic                req_valid = 1'b0;
    logic                dsel = 1'b0;
    logic                slow = 1'b0;
    logic                wide = 1'b0;
    logic                req_ready, rsp_valid, rd_n, wr_n, oe, rdy;
    iptm_pkg::iptm_req_s req = '0;
    iptm_pkg::iptm_cfg_s cfg = '0;
    logic [31:0]         rsp_rdata, w, lat, rd, g, pins;
    logic [15:0]         din, dout;
    logic [2:0]          addr;
    logic [1:0]          cs_n;
    int                  n_mismatch = 0;
    int                  comparisons = 0;

    always #5 clk = ~clk;

    iptm_engine DUT (.clk(clk), .resetn(resetn), .clk_en(1'b1),
        .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .cfg(cfg),
        .target_drive(dsel), .ide_addr_lines(addr),
        .ide_chip_selects_n(cs_n), .ide_read_strobe_n(rd_n),
        .ide_write_strobe_n(wr_n), .ide_data_in(din),
        .ide_data_out(dout), .ide_data_oe(oe), .drive_io_ready(rdy));

    iptm_drive_model drive (.clk(clk), .cs_n(cs_n), .rd_n(rd_n),
        .wr_n(wr_n), .slow(slow), .data(din), .ready(rdy));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic summarize;
        $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // one access, 32-bit when wide is set; counts strobe clocks, deselected clocks and cycles to the response
    task automatic xfer(input logic d, input logic wr);
        int i;
        while (req_ready !== 1'b1) @(negedge clk);
        req = '0;
        req.is_data = d;
        req.write = wr;
        req.is32 = wide;
        req.cs_sel = 2'h1;
        req.addr = d ? 3'h0 : 3'h7;
        req.wdata = 32'h0000a55a;
        req_valid = 1'b1;
        @(negedge clk);
        req_valid = 1'b0;
        w = '0;
        g = '0;
        lat = '0;
        i = 1;
        do begin
            if (rsp_valid === 1'b1) begin
                rd = rsp_rdata;
                lat = i;
            end
            if (rd_n === 1'b0 || wr_n === 1'b0) begin
                w = w + 32'h1;
                pins = {oe, 9'h0, cs_n, 1'h0, addr, dout};
            end
            if (cs_n === 2'h3) g = g + 32'h1;
            i++;
            @(negedge clk);
        end while (req_ready !== 1'b1 && i < 400);
        if (i >= 400) n_mismatch++;
    endtask

    task automatic t_compat;
        cfg = '0;
        xfer(1'b1, 1'b0);
        chk(w, 32'(iptm_pkg::CDATA_ISP));
        chk(rd, 32'h0000c35a);
        chk(g, 32'(iptm_pkg::CS_GAP_CLKS));
        $display("t_compat done");
    endtask

    // isa recovery set too: it must not lengthen the fast read
    task automatic t_enh;
        cfg = '0;
        cfg.drive0_fast_en = 1'b1;
        cfg.isa_recovery_timer_16b_en = 1'b1;
        cfg.primary_drive_timing_reg = 4'he;
        xfer(1'b1, 1'b0);
        chk(w, 32'(iptm_pkg::ENH_ISP_BASE) + 32'h3);
        chk(lat, 32'(iptm_pkg::ENH_STARTUP + iptm_pkg::ENH_ISP_BASE
            + iptm_pkg::ENH_RCT_BASE) + 32'h6);
        cfg.separate_drive1_timing_en = 1'b1;
        cfg.drive1_fast_en = 1'b1;
        cfg.drive1_alt_timing_reg = 4'h4;
        dsel = 1'b1;
        xfer(1'b1, 1'b0);
        chk(w, 32'(iptm_pkg::ENH_ISP_BASE) + 32'h1);
        dsel = 1'b0;
        $display("t_enh done");
    endtask

    task automatic t_ndata;
        cfg = '0;
        cfg.drive0_fast_en = 1'b1;
        xfer(1'b0, 1'b0);
        chk(w, 32'(iptm_pkg::NDATA_ISP));
        chk(pins & 32'hffff0000, 32'h00270000);
        $display("t_ndata done");
    endtask

    task automatic t_wait;
        cfg = '0;
        cfg.drive0_fast_en = 1'b1;
        cfg.drive0_ready_sample_en = 1'b1;
        slow = 1'b1;
        xfer(1'b1, 1'b0);
        chk({31'h0, w >= 32'h4}, 32'h1);
        slow = 1'b0;
        xfer(1'b1, 1'b0);
        chk(w, 32'(iptm_pkg::ENH_ISP_BASE));
        $display("t_wait done");
    endtask

    task automatic t_post;
        cfg = '0;
        cfg.drive0_fast_en = 1'b1;
        cfg.post_en = 1'b1;
        xfer(1'b1, 1'b1);
        chk({31'h0, lat <= 32'h2}, 32'h1);
        chk(w, 32'(iptm_pkg::ENH_ISP_BASE));
        chk(pins, 32'h8020a55a);
        $display("t_post done");
    endtask

    // compatible halves sit apart; fast halves and prefetch run packed
    task automatic t_wide;
        cfg = '0;
        wide = 1'b1;
        xfer(1'b1, 1'b0);
        chk(w, 32'(iptm_pkg::CDATA_ISP) * 32'h2);
        chk(g, 32'(iptm_pkg::CS_GAP_CLKS) * 32'h2);
        chk(rd, 32'hc35ac35a);
        cfg.drive0_fast_en = 1'b1;
        cfg.prefetch_en = 1'b1;
        xfer(1'b1, 1'b0);
        chk(w, 32'(iptm_pkg::ENH_ISP_BASE) * 32'h4);
        chk(g, 32'(iptm_pkg::CS_GAP_CLKS));
        xfer(1'b1, 1'b0);
        chk(lat, 32'h1);
        chk(rd, 32'hc35ac35a);
        wide = 1'b0;
        $display("t_wide done");
    endtask

    initial begin
        repeat (12) @(negedge clk);
        resetn = 1'b1;
        t_compat();
        t_enh();
        t_ndata();
        t_wait();
        t_post();
        t_wide();
        summarize();
    end

    // ten short accesses need well under 10 us; allow six times that
    initial begin
        #60000;
        n_mismatch++;
        summarize();
    end
endmodule
`default_nettype wire
